// ### conv_ctrl.sv
/*
 * converter_meas_and_clock_sync: digital control around two bucks and a
 * boost. mode selection, load measurement, dithering and sync-clock check.
 * assumes one 20 mhz clock, an analog sampler giving the 9-bit load code,
 * and a sync clock pin sampled as an ordinary asynchronous input.
 */
// Local design decisions: the address-and-strobe port and the placing of the registers.
// Operation
// - writing the measurement select register picks a buck and starts measuring
// - measured buck forced to pwm; sequence ends within 50 us
// - completion sets measurement-done flag; mask bit keeps it off the interrupt
// - result is 9 bits, low eight in first register, msb in second
// - one count equals 20 ma, full scale 10.22 a
// - without forced pwm, buck runs pwm from 520 ma, pfm below
// - forced pwm option keeps a fixed frequency at every load
// - boost voltage setting spans 4.9 v to 5.2 v in 0.1 v steps
// - boost discharge bit gates pulldown when disabled; defaults on
// - boost always runs forced pwm at constant frequency
// - boost regulate or bypass mode fixed by otp, never changeable
// - dithered frequency swings between 0.85 and 1.0 of nominal
// - dithering only with pll off on rc clock; affects all converters
// - five-bit field sets nominal sync clock 1 to 24 mhz
// - sync clock must lie within -30 % to +10 % to count as valid
// - with pll on, missing clock at startup or activation raises sync flag
// - sync mask bit keeps sync flag off the interrupt output
// - standby with pll off: detector off, no sync flag, rc clock
`timescale 1ns/1ps
module conv_ctrl (
    input  wire logic       clk_i,          // 20 mhz system clock
    input  wire logic       arst_n_i,       // async reset, active low
    input  wire logic [7:0] addr_i,         // register address
    input  wire logic [7:0] wdata_i,        // register write data
    input  wire logic       wr_i,           // write strobe
    input  wire logic       rd_i,           // read strobe
    output logic      [7:0] rdata_o,        // read data, cycle after rd_i
    output logic            irq_o,          // level interrupt
    input  wire logic       sync_clock_input,  // external sync clock pin
    input  wire logic [8:0] load_code_i,    // sampled buck load code, 20 ma lsb
    input  wire logic       otp_done_i,     // otp load finished
    input  wire logic       conv_enable_i,  // any converter enable request
    input  wire logic       otp_bypass_i,   // otp boost bypass strap
    output logic            buck0_pwm_o,    // buck0 runs pwm (else pfm)
    output logic            buck1_pwm_o,    // buck1 runs pwm (else pfm)
    output logic            meas_sel_o,     // buck under measurement
    output logic            meas_busy_o,    // measurement running
    output logic            boost_pwm_o,    // boost forced pwm
    output logic      [1:0] step_up_voltage_setting_o,   // boost target code, 4.9 v + n x 0.1 v
    output logic            boost_pulldown_o, // boost output discharge
    output logic            boost_bypass_o, // boost runs as load switch
    output logic            use_ext_clk_o,  // converters follow the pll
    output logic            dither_en_o,    // spread spectrum active
    output logic      [3:0] dither_step_o,  // percent below nominal, 0..15
    output logic            pll_det_en_o    // pll and clock detector powered
);

    // =====================================================================
    // registers
    // =====================================================================
    logic [7:0] buck_cfg_reg;
    logic [7:0] boost_cfg_reg;
    logic [7:0] clk_cfg_reg;
    logic [1:0] int_stat_reg;
    logic [1:0] int_mask_reg;
    logic       meas_sel_reg;
    logic [8:0] load_reg;
    logic       bypass_reg;
    logic       bypass_cap_reg;
    conv_ctrl_pkg::reg_req_s req;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    function automatic logic is_wr(input conv_ctrl_pkg::reg_req_s r, input logic [7:0] a);
        is_wr = r.wr && (r.addr == a);
    endfunction : is_wr

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            buck_cfg_reg  <= conv_ctrl_pkg::BUCK_CFG_RST;
            boost_cfg_reg <= conv_ctrl_pkg::BOOST_CFG_RST;
            clk_cfg_reg   <= conv_ctrl_pkg::CLK_CFG_RST;
            int_mask_reg  <= 2'h0;
            meas_sel_reg  <= 1'b0;
        end
        else
        begin
            if (is_wr(req, conv_ctrl_pkg::ADDR_BUCK_CFG))
                buck_cfg_reg <= {6'h00, req.wdata[1:0]};
            if (is_wr(req, conv_ctrl_pkg::ADDR_BOOST_CFG))
                boost_cfg_reg <= {5'h00, req.wdata[2:0]};
            if (is_wr(req, conv_ctrl_pkg::ADDR_CLK_CFG))
                clk_cfg_reg <= {1'b0, req.wdata[6:0]};
            if (is_wr(req, conv_ctrl_pkg::ADDR_INT_MASK))
                int_mask_reg <= req.wdata[1:0];
            if (is_wr(req, conv_ctrl_pkg::ADDR_MEAS_SEL))
                meas_sel_reg <= req.wdata[0];
        end
    end

    // boost mode caught once after reset release and then frozen
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bypass_reg     <= 1'b0;
            bypass_cap_reg <= 1'b0;
        end
        else if (!bypass_cap_reg)
        begin
            bypass_reg     <= otp_bypass_i;
            bypass_cap_reg <= 1'b1;
        end
    end

    // =====================================================================
    // load-current measurement
    // =====================================================================
    logic [10:0] meas_cnt_reg;
    logic        meas_busy_reg;
    logic        meas_done;
    localparam logic [10:0] MEAS_LAST = 11'(conv_ctrl_pkg::MEAS_CYCLES - 1);

    assign meas_done = meas_busy_reg && (meas_cnt_reg == MEAS_LAST);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meas_busy_reg <= 1'b0;
            meas_cnt_reg  <= 11'h000;
        end
        else if (is_wr(req, conv_ctrl_pkg::ADDR_MEAS_SEL))
        begin
            meas_busy_reg <= 1'b1;
            meas_cnt_reg  <= 11'h000;
        end
        else if (meas_done)
        begin
            meas_busy_reg <= 1'b0;
        end
        else if (meas_busy_reg)
        begin
            meas_cnt_reg <= meas_cnt_reg + 11'h001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            load_reg <= 9'h000;
        else if (meas_done)
            load_reg <= load_code_i;
    end

    // =====================================================================
    // buck and boost mode
    // =====================================================================
    logic load_heavy;

    assign load_heavy = (load_code_i >= conv_ctrl_pkg::PFM_EXIT_CODE);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            buck0_pwm_o <= 1'b0;
            buck1_pwm_o <= 1'b0;
        end
        else
        begin
            buck0_pwm_o <= buck_cfg_reg[conv_ctrl_pkg::BUCK0_FPWM_BIT] || load_heavy
                           || (meas_busy_reg && !meas_sel_reg);
            buck1_pwm_o <= buck_cfg_reg[conv_ctrl_pkg::BUCK1_FPWM_BIT] || load_heavy
                           || (meas_busy_reg && meas_sel_reg);
        end
    end

    assign boost_pwm_o      = 1'b1;
    assign step_up_voltage_setting_o     = boost_cfg_reg[1:0];
    assign boost_pulldown_o = boost_cfg_reg[conv_ctrl_pkg::BOOST_DIS_BIT] && !conv_enable_i;
    assign boost_bypass_o   = bypass_reg;
    assign meas_sel_o       = meas_sel_reg;
    assign meas_busy_o      = meas_busy_reg;

    // =====================================================================
    // clock selection and spread spectrum
    // =====================================================================
    logic       pll_on;
    logic [4:0] nom_mhz;
    logic [3:0] dither_reg;
    logic       dither_up_reg;

    assign pll_on        = clk_cfg_reg[conv_ctrl_pkg::CLK_PLL_BIT];
    assign nom_mhz       = clk_cfg_reg[4:0];
    assign dither_en_o   = clk_cfg_reg[conv_ctrl_pkg::CLK_DITHER_BIT] && !pll_on;
    assign use_ext_clk_o = pll_on;
    assign pll_det_en_o  = pll_on;
    assign dither_step_o = dither_reg;

    // triangle sweep 0..15 % below nominal
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dither_reg    <= 4'h0;
            dither_up_reg <= 1'b1;
        end
        else if (!dither_en_o)
        begin
            dither_reg    <= 4'h0;
            dither_up_reg <= 1'b1;
        end
        else if (dither_up_reg)
        begin
            dither_reg    <= dither_reg + 4'h1;
            dither_up_reg <= (dither_reg != 4'(conv_ctrl_pkg::DITHER_STEPS - 1));
        end
        else
        begin
            dither_reg    <= dither_reg - 4'h1;
            dither_up_reg <= (dither_reg == 4'h1);
        end
    end

    // =====================================================================
    // sync clock detector
    // =====================================================================
    logic [2:0]  sync_sh_reg;
    logic        sync_lvl_reg;
    logic        sync_rise;
    logic [7:0]  win_cnt_reg;
    logic [8:0]  edge_cnt_reg;
    logic        clk_valid_reg;
    logic [8:0]  lo_lim;
    logic [8:0]  hi_lim;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync_sh_reg  <= 3'h0;
            sync_lvl_reg <= 1'b0;
        end
        else
        begin
            sync_sh_reg <= {sync_sh_reg[1:0], sync_clock_input};
            if (sync_sh_reg[1] == sync_sh_reg[2])
                sync_lvl_reg <= sync_sh_reg[2];
        end
    end

    assign sync_rise = (sync_sh_reg[1] == sync_sh_reg[2]) && sync_sh_reg[2] && !sync_lvl_reg;

    // edges per window: nominal x 10, window -30 % .. +10 %
    assign lo_lim = 9'(nom_mhz * 7);
    assign hi_lim = 9'(nom_mhz * 11);

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            win_cnt_reg   <= 8'h00;
            edge_cnt_reg  <= 9'h000;
            clk_valid_reg <= 1'b0;
        end
        else if (!pll_on)
        begin
            win_cnt_reg   <= 8'h00;
            edge_cnt_reg  <= 9'h000;
            clk_valid_reg <= 1'b0;
        end
        else if (win_cnt_reg == 8'(conv_ctrl_pkg::DET_WIN_CYC - 1))
        begin
            win_cnt_reg   <= 8'h00;
            edge_cnt_reg  <= 9'h000;
            clk_valid_reg <= (nom_mhz != 5'h00) && (edge_cnt_reg >= lo_lim)
                             && (edge_cnt_reg <= hi_lim);
        end
        else
        begin
            win_cnt_reg <= win_cnt_reg + 8'h01;
            if (sync_rise && edge_cnt_reg != 9'h1ff)
                edge_cnt_reg <= edge_cnt_reg + 9'h001;
        end
    end

    // =====================================================================
    // power state and sync-clock event
    // =====================================================================
    conv_ctrl_pkg::pwr_state_e pwr_state_reg;
    logic sync_event;

    assign sync_event = pll_on && !clk_valid_reg
                        && ((pwr_state_reg == conv_ctrl_pkg::ST_OTP_LOAD && otp_done_i)
                        || (pwr_state_reg == conv_ctrl_pkg::ST_STANDBY && conv_enable_i));

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pwr_state_reg <= conv_ctrl_pkg::ST_OTP_LOAD;
        else
        begin
            case (pwr_state_reg)
                conv_ctrl_pkg::ST_OTP_LOAD:
                    if (otp_done_i)
                        pwr_state_reg <= conv_ctrl_pkg::ST_STANDBY;
                conv_ctrl_pkg::ST_STANDBY:
                    if (conv_enable_i)
                        pwr_state_reg <= conv_ctrl_pkg::ST_ACTIVE;
                conv_ctrl_pkg::ST_ACTIVE:
                    if (!conv_enable_i)
                        pwr_state_reg <= conv_ctrl_pkg::ST_STANDBY;
                default:
                    pwr_state_reg <= conv_ctrl_pkg::ST_OTP_LOAD;
            endcase
        end
    end

    // =====================================================================
    // interrupts: sticky, write one to clear, set wins
    // =====================================================================
    logic [1:0] int_set;
    logic [1:0] int_clr;

    assign int_set = {sync_event, meas_done};
    assign int_clr = is_wr(req, conv_ctrl_pkg::ADDR_INT_STAT) ? req.wdata[1:0] : 2'h0;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            int_stat_reg <= 2'h0;
        else
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
    end

    assign irq_o = |(int_stat_reg & ~int_mask_reg);

    // =====================================================================
    // read port
    // =====================================================================
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 8'h00;
        else if (req.rd)
        begin
            case (req.addr)
                conv_ctrl_pkg::ADDR_MEAS_SEL:  rdata_o <= {7'h00, meas_sel_reg};
                conv_ctrl_pkg::ADDR_LOAD_LO:   rdata_o <= load_reg[7:0];
                conv_ctrl_pkg::ADDR_LOAD_HI:   rdata_o <= {7'h00, load_reg[8]};
                conv_ctrl_pkg::ADDR_INT_STAT:  rdata_o <= {6'h00, int_stat_reg};
                conv_ctrl_pkg::ADDR_INT_MASK:  rdata_o <= {6'h00, int_mask_reg};
                conv_ctrl_pkg::ADDR_BUCK_CFG:  rdata_o <= buck_cfg_reg;
                conv_ctrl_pkg::ADDR_BOOST_CFG: rdata_o <= boost_cfg_reg;
                conv_ctrl_pkg::ADDR_CLK_CFG:   rdata_o <= clk_cfg_reg;
                conv_ctrl_pkg::ADDR_STATUS:    rdata_o <= {4'h0, bypass_reg, clk_valid_reg,
                                                           meas_busy_reg, dither_en_o};
                default:                       rdata_o <= 8'h00;
            endcase
        end
        else
            rdata_o <= 8'h00;
    end

    // =====================================================================
    // checks
    // =====================================================================
    chk_meas_start_busy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        is_wr(req, conv_ctrl_pkg::ADDR_MEAS_SEL) |=> meas_busy_reg)
        else $error("measurement did not start");

    chk_meas_ends_bound: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (meas_busy_reg && meas_cnt_reg == 11'h000 && !$past(meas_busy_reg))
        |-> ##[1:1000] !meas_busy_reg)
        else $error("measurement overran");

    chk_meas_forces_pwm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $past(meas_busy_reg) |-> ($past(meas_sel_reg) ? buck1_pwm_o : buck0_pwm_o))
        else $error("measured buck not in pwm");

    chk_done_sets_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        meas_done |=> int_stat_reg[conv_ctrl_pkg::INT_MEAS_BIT])
        else $error("done flag not set");

    chk_result_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !meas_done |=> $stable(load_reg))
        else $error("result changed without completion");

    chk_boost_always_pwm: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        boost_pwm_o)
        else $error("boost left pwm");

    chk_dither_gated_pll: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pll_on |-> !dither_en_o)
        else $error("dither active with pll");

    chk_dither_range: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        dither_en_o && dither_reg == 4'(conv_ctrl_pkg::DITHER_STEPS)
        |=> dither_reg == 4'(conv_ctrl_pkg::DITHER_STEPS - 1))
        else $error("dither did not turn at 15 percent");

    chk_sync_mask_irq: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        int_mask_reg[conv_ctrl_pkg::INT_SYNC_BIT] && !int_stat_reg[conv_ctrl_pkg::INT_MEAS_BIT] |-> !irq_o)
        else $error("masked flag reached irq");

    chk_no_sync_pll_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !pll_on && !int_stat_reg[conv_ctrl_pkg::INT_SYNC_BIT] |=> !int_stat_reg[conv_ctrl_pkg::INT_SYNC_BIT])
        else $error("sync flag with pll off");

    chk_bypass_frozen: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $past(bypass_cap_reg) |-> $stable(bypass_reg))
        else $error("boost mode changed");

endmodule : conv_ctrl

// ### conv_ctrl_pkg.sv
/*
 * package for the converter measurement and sync-clock control block:
 * register offsets, field positions, reset values and timing counts.
 * assumes a 20 mhz system clock and a plain strobe register port.
 */
package conv_ctrl_pkg;

    // =====================================================================
    // register map (byte offsets, one 8-bit register per offset)
    // =====================================================================
    localparam logic [7:0] ADDR_MEAS_SEL   = 8'h00;
    localparam logic [7:0] ADDR_LOAD_LO    = 8'h01;
    localparam logic [7:0] ADDR_LOAD_HI    = 8'h02;
    localparam logic [7:0] ADDR_INT_STAT   = 8'h03;
    localparam logic [7:0] ADDR_INT_MASK   = 8'h04;
    localparam logic [7:0] ADDR_BUCK_CFG   = 8'h05;
    localparam logic [7:0] ADDR_BOOST_CFG  = 8'h06;
    localparam logic [7:0] ADDR_CLK_CFG    = 8'h07;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int INT_MEAS_BIT     = 0;
    localparam int INT_SYNC_BIT     = 1;
    localparam int BUCK0_FPWM_BIT   = 0;
    localparam int BUCK1_FPWM_BIT   = 1;
    localparam int BOOST_DIS_BIT    = 2;
    localparam int CLK_PLL_BIT      = 5;
    localparam int CLK_DITHER_BIT   = 6;

    // =====================================================================
    // reset values and boost voltage code limit
    // =====================================================================
    localparam logic [7:0] BUCK_CFG_RST  = 8'h00;
    localparam logic [7:0] BOOST_CFG_RST = 8'h04;   // discharge on
    localparam logic [7:0] CLK_CFG_RST   = 8'h00;
    localparam logic [1:0] VSET_MAX      = 2'h3;    // 4.9 v + 3 x 0.1 v

    // =====================================================================
    // analog thresholds and scaling
    // =====================================================================
    localparam int         LOAD_LSB_MA   = 20;
    localparam logic [8:0] PFM_EXIT_CODE = 9'h01a;  // 520 ma / 20 ma

    // =====================================================================
    // timing
    // =====================================================================
    localparam int CLK_HZ        = 20_000_000;
    localparam int MEAS_MAX_NS   = 50_000;
    localparam int MEAS_CYCLES   = (MEAS_MAX_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int DET_WIN_NS    = 10_000;   // detector gate 10 us
    localparam int DET_WIN_CYC   = (DET_WIN_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int MHZ_PER_WIN   = DET_WIN_NS / 1000;  // edges per mhz per window
    localparam int DITHER_STEPS  = 15;                 // 0.85 .. 1.00 in 1 % steps

    typedef enum logic [1:0] {ST_OTP_LOAD, ST_STANDBY, ST_ACTIVE} pwr_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage : conv_ctrl_pkg

// ### conv_ctrl_tb.sv
/*
 * self-checking bench for conv_ctrl.
 * assumes the register map and timing of conv_ctrl_pkg.
 */
`timescale 1ns/1ps
module conv_ctrl_tb;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [8:0] load_code_i = 9'h000;
    logic       conv_enable_i = 1'b0;
    logic       run = 1'b0;
    logic       sclk;
    logic [7:0] rdata_o;
    logic       irq_o, b0_pwm, b1_pwm, sel, busy, bpwm, pdn, byp, ext, den, det;
    logic [1:0] vset;
    logic [3:0] dstep;
    logic       byp_strap = 1'b1;
    int         n_fail = 0;
    int         total_checks = 0;

    always #25 clk_i = ~clk_i;

    ext_sync_clock src (.run_i(run), .clk_o(sclk));

    conv_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .sync_clock_input(sclk), .load_code_i(load_code_i),
        .otp_done_i(1'b1), .conv_enable_i(conv_enable_i), .otp_bypass_i(byp_strap), .buck0_pwm_o(b0_pwm),
        .buck1_pwm_o(b1_pwm), .meas_sel_o(sel), .meas_busy_o(busy), .boost_pwm_o(bpwm),
        .step_up_voltage_setting_o(vset), .boost_pulldown_o(pdn), .boost_bypass_o(byp), .use_ext_clk_o(ext),
        .dither_en_o(den), .dither_step_o(dstep), .pll_det_en_o(det));

    // =====================================================================
    // bus and compare tasks
    // =====================================================================
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, {8'h00, exp}, {8'h00, rdata_o});
    endtask : rchk

    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic t_regs;
        rchk(8'h05, 8'h00, "buck cfg");
        rchk(8'h06, 8'h04, "boost cfg");
        rchk(8'h3c, 8'h00, "unmapped");
        chk("boost pwm", 16'h1, {15'h0, bpwm});
        chk("pulldown", 16'h1, {15'h0, pdn});
        chk("bypass", 16'h1, {15'h0, byp});
        byp_strap <= 1'b0;
        wr(8'h06, 8'h03);
        settle();
        chk("bypass held", 16'h1, {15'h0, byp});
        chk("vset", 16'h3, {14'h0, vset});
        chk("pulldown off", 16'h0, {15'h0, pdn});
        $display("test regs done");
    endtask : t_regs

    task automatic t_modes;
        load_code_i <= 9'd26;
        settle();
        chk("pwm at 520", 16'h1, {15'h0, b0_pwm});
        load_code_i <= 9'd25;
        settle();
        chk("pfm below", 16'h0, {15'h0, b0_pwm});
        wr(8'h05, 8'h01);
        settle();
        chk("forced pwm", 16'h1, {15'h0, b0_pwm});
        wr(8'h05, 8'h00);
        $display("test modes done");
    endtask : t_modes

    task automatic t_meas;
        int n;
        wr(8'h00, 8'h01);
        @(posedge clk_i);
        @(posedge clk_i);
        #1;
        chk("busy sel", 16'h3, {14'h0, busy, sel});
        chk("meas pwm", 16'h2, {14'h0, b1_pwm, b0_pwm});
        load_code_i <= 9'h1ff;
        n = 2;
        while (busy === 1'b1 && n < 1100)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("meas length", 16'd1000, n[15:0]);
        load_code_i <= 9'h000;
        rchk(8'h01, 8'hff, "result lo");
        rchk(8'h02, 8'h01, "result hi");
        rchk(8'h03, 8'h01, "meas flag");
        chk("irq", 16'h1, {15'h0, irq_o});
        wr(8'h04, 8'h01);
        settle();
        chk("irq masked", 16'h0, {15'h0, irq_o});
        rchk(8'h01, 8'hff, "result kept");
        wr(8'h03, 8'h01);
        wr(8'h04, 8'h00);
        $display("test meas done");
    endtask : t_meas

    task automatic t_clock;
        rchk(8'h03, 8'h00, "no sync flag");
        wr(8'h07, 8'h40);
        settle();
        chk("dither on", 16'h1, {15'h0, den});
        chk("dither step", 16'h3, {12'h0, dstep});
        repeat (12) @(posedge clk_i);
        #1;
        chk("dither deepest", 16'hf, {12'h0, dstep});
        wr(8'h07, 8'h61);
        settle();
        chk("dither pll", 16'h1, {14'h0, den, ext});
        conv_enable_i <= 1'b1;
        settle();
        rchk(8'h03, 8'h02, "sync flag");
        chk("sync irq", 16'h1, {15'h0, irq_o});
        wr(8'h04, 8'h02);
        settle();
        chk("sync masked", 16'h0, {15'h0, irq_o});
        run <= 1'b1;
        repeat (700) @(posedge clk_i);
        rchk(8'h08, 8'h0c, "clock valid");
        $display("test clock done");
    endtask : t_clock

    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    initial
    begin
        #500000;
        n_fail++;
        complete_run();
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_modes();
        t_meas();
        t_clock();
        complete_run();
    end
endmodule : conv_ctrl_tb

// ### ext_sync_clock.sv
/*
 * external sync clock source driving the sync clock pin.
 * assumes the bench gates it; the line stands low outside bursts.
 */
`timescale 1ns/1ps
module ext_sync_clock #(
    parameter int HALF_NS = 500
) (
    input  wire logic run_i,  // clock runs while high
    output logic      clk_o   // sync clock pin
);
    initial clk_o = 1'b0;
    always
    begin
        #(HALF_NS);
        clk_o = run_i ? ~clk_o : 1'b0;
    end
endmodule : ext_sync_clock
